// [mrsd_pkg.sv]
package mrsd_pkg;
	localparam int X_COUNT = 32;
	localparam int Y_COUNT = 16;
	localparam int DATA_WIDTH = 16;
	localparam int ADDR_HALF_WIDTH = 8;
	localparam int BOARD_WORDS = 1024;
	localparam int DEF_ROM_WORDS = 1024;
	localparam int ROW_BIT = 7;
	localparam int BOARD_LO_BIT = 4;
	localparam int BOARD_HI_BIT = 5;
	localparam int X_HIGH_BIT = 6;
	localparam int Y_HIGH_BIT = 7;
	localparam logic [3:0] STROBE_IDLE = 4'h0;
	localparam logic [DATA_WIDTH-1:0] DATA_RESET = 16'h0000;
endpackage

// [mrsd_onehot.sv]
`timescale 1ns/1ps
module mrsd_onehot import mrsd_pkg::*; #(
	parameter int WIDTH = 4,
	parameter int OUTS = 16
) (
	input wire logic [WIDTH-1:0] i_index,
	input wire logic i_enable,
	output logic [OUTS-1:0] o_select
);
	// one-hot decode, gated by enable
	always_comb begin
		o_select = '0;
		if (i_enable) begin
			o_select[i_index] = 1'b1;
		end
	end
endmodule

// [mrsd_readout.sv]
`timescale 1ns/1ps
module mrsd_readout import mrsd_pkg::*; #(
	parameter int WIDTH = DATA_WIDTH
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_row_a_amp_clock,
	input wire logic i_row_b_amp_clock,
	input wire logic [WIDTH-1:0] i_row_a_sense,
	input wire logic [WIDTH-1:0] i_row_b_sense,
	output logic [WIDTH-1:0] o_data_reg_set_line,
	output logic [WIDTH-1:0] o_data_reg_clear_line
);
	// only the clocked row is sampled; idle shows set low, clear low
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_data_reg_set_line <= DATA_RESET;
			o_data_reg_clear_line <= DATA_RESET;
		end else if (i_row_a_amp_clock) begin
			o_data_reg_set_line <= i_row_a_sense;
			o_data_reg_clear_line <= ~i_row_a_sense;
		end else if (i_row_b_amp_clock) begin
			o_data_reg_set_line <= i_row_b_sense;
			o_data_reg_clear_line <= ~i_row_b_sense;
		end else begin
			o_data_reg_set_line <= DATA_RESET;
			o_data_reg_clear_line <= DATA_RESET;
		end
	end
endmodule

// [mrsd_top.sv]
`timescale 1ns/1ps
// How it works
// (RQ1) upper 4,5 and lower 7 pick strobe
// (RQ2) x index from lower 0-3, upper 6
// (RQ3) y index from lower 4-6, upper 7
// (RQ4) board bits count only above 1024 words
// (RQ5) even words row A, odd row B
// (RQ6) each data bit drives set and clear
// (RQ7) drive pulse follows processor drive timing
// (RQ8) local strobe follows processor strobe timing
// (RQ9) thirty-two one-hot x selects
// (RQ10) sixteen one-hot y selects
// (RQ11) never more than one select active
// (RQ12) separate clocks for row A, row B
// (RQ13) y switch on only during drive pulse
// (RQ14) strobe active whenever a row clock is
// (RQ15) processor holds address through the access
module mrsd_top import mrsd_pkg::*; #(
	parameter int ROM_WORDS = DEF_ROM_WORDS
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [ADDR_HALF_WIDTH-1:0] i_rom_addr_upper,
	input wire logic [ADDR_HALF_WIDTH-1:0] i_rom_addr_lower,
	input wire logic i_proc_drive_timing,
	input wire logic i_proc_strobe_timing,
	input wire logic [DATA_WIDTH-1:0] i_row_a_sense,
	input wire logic [DATA_WIDTH-1:0] i_row_b_sense,
	output logic [X_COUNT-1:0] o_x_switch_select,
	output logic [Y_COUNT-1:0] o_y_switch_select,
	output logic o_current_drive_pulse,
	output logic o_local_strobe,
	output logic o_board1_row_a_strobe_en,
	output logic o_board1_row_b_strobe_en,
	output logic o_board2_row_a_strobe_en,
	output logic o_board2_row_b_strobe_en,
	output logic o_row_a_amp_clock,
	output logic o_row_b_amp_clock,
	output logic [DATA_WIDTH-1:0] o_data_reg_set_line,
	output logic [DATA_WIDTH-1:0] o_data_reg_clear_line
);
	localparam bit MULTI_BOARD = (ROM_WORDS > BOARD_WORDS);

	logic rst_meta;
	logic rst_n;
	logic [4:0] x_index;
	logic [3:0] y_index;
	logic second_board;
	logic odd_word;
	logic x_enable;
	logic [3:0] strobe_sel;
	logic [3:0] next_strobe_sel;

	// reset release through two flops
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// drive and strobe pulses registered from processor timing
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_current_drive_pulse <= 1'b0;
			o_local_strobe <= 1'b0;
		end else begin
			o_current_drive_pulse <= i_proc_drive_timing; // RQ7
			o_local_strobe <= i_proc_strobe_timing; // RQ8
		end
	end

	// address field extraction
	// upper address bit of each field is the most significant, then the lower bits lowest-numbered first
	assign x_index = {i_rom_addr_upper[X_HIGH_BIT], i_rom_addr_lower[0], i_rom_addr_lower[1],
		i_rom_addr_lower[2], i_rom_addr_lower[3]}; // RQ2
	assign y_index = {i_rom_addr_upper[Y_HIGH_BIT], i_rom_addr_lower[4], i_rom_addr_lower[5],
		i_rom_addr_lower[6]}; // RQ3
	assign odd_word = i_rom_addr_lower[ROW_BIT]; // RQ5
	// above 1024 words, board bit 4 suppresses every strobe enable when set, only bit 5 picks board
	assign second_board = MULTI_BOARD && i_rom_addr_upper[BOARD_HI_BIT]; // RQ4
	// x current gated by the same drive pulse as y
	assign x_enable = o_current_drive_pulse;

	mrsd_onehot #(
		.WIDTH(5),
		.OUTS(X_COUNT)
	) u_x_decode (
		.i_index(x_index),
		.i_enable(x_enable),
		.o_select(o_x_switch_select)
	); // RQ9 RQ11

	mrsd_onehot #(
		.WIDTH(4),
		.OUTS(Y_COUNT)
	) u_y_decode (
		.i_index(y_index),
		.i_enable(o_current_drive_pulse),
		.o_select(o_y_switch_select)
	); // RQ10 RQ11 RQ13

	// strobe enable decode: one of four, or none outside strobe or, above 1024 words, when board bit 4 is set
	always_comb begin
		next_strobe_sel = STROBE_IDLE;
		if (i_proc_strobe_timing && !(MULTI_BOARD && i_rom_addr_upper[BOARD_LO_BIT])) begin
			next_strobe_sel[{second_board, odd_word}] = 1'b1; // RQ1
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_sel <= STROBE_IDLE;
		end else begin
			strobe_sel <= next_strobe_sel;
		end
	end

	assign o_board1_row_a_strobe_en = strobe_sel[0];
	assign o_board1_row_b_strobe_en = strobe_sel[1];
	assign o_board2_row_a_strobe_en = strobe_sel[2];
	assign o_board2_row_b_strobe_en = strobe_sel[3];
	// row clocks only within local strobe
	assign o_row_a_amp_clock = o_local_strobe && (strobe_sel[0] || strobe_sel[2]); // RQ12 RQ14
	assign o_row_b_amp_clock = o_local_strobe && (strobe_sel[1] || strobe_sel[3]); // RQ12 RQ14

	mrsd_readout #(
		.WIDTH(DATA_WIDTH)
	) u_readout (
		.i_core_clk(i_core_clk),
		.i_rst_n(rst_n),
		.i_row_a_amp_clock(o_row_a_amp_clock),
		.i_row_b_amp_clock(o_row_b_amp_clock),
		.i_row_a_sense(i_row_a_sense),
		.i_row_b_sense(i_row_b_sense),
		.o_data_reg_set_line(o_data_reg_set_line),
		.o_data_reg_clear_line(o_data_reg_clear_line)
	); // RQ6
endmodule

// [mrsd_top_assertions.sv]
`timescale 1ns/1ps
module mrsd_top_chk (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_rom_addr_upper,
	input wire logic [7:0] i_rom_addr_lower,
	input wire logic i_proc_drive_timing,
	input wire logic i_proc_strobe_timing,
	input wire logic [31:0] o_x_switch_select,
	input wire logic [15:0] o_y_switch_select,
	input wire logic o_current_drive_pulse,
	input wire logic o_local_strobe,
	input wire logic o_row_a_amp_clock,
	input wire logic o_row_b_amp_clock,
	input wire logic [15:0] o_data_reg_set_line,
	input wire logic [15:0] o_data_reg_clear_line
);
	logic [1:0] up;
	logic [4:0] xi;
	logic [3:0] yi;
	logic ra;
	logic rb;
	assign ra = o_row_a_amp_clock;
	assign rb = o_row_b_amp_clock;
	assign xi = {i_rom_addr_upper[6], i_rom_addr_lower[0], i_rom_addr_lower[1],
		i_rom_addr_lower[2], i_rom_addr_lower[3]};
	assign yi = {i_rom_addr_upper[7], i_rom_addr_lower[4], i_rom_addr_lower[5],
		i_rom_addr_lower[6]};
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			up <= 2'h0;
		else if (up != 2'h3)
			up <= up + 2'h1;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	drive_follow_a: assert property (up == 2'h3 |=>
		o_current_drive_pulse == $past(i_proc_drive_timing)) else $error("drive pulse");
	strobe_follow_a: assert property (up == 2'h3 |=>
		o_local_strobe == $past(i_proc_strobe_timing)) else $error("local strobe");
	x_select_a: assert property (o_x_switch_select ==
		(o_current_drive_pulse ? 32'h0000_0001 << xi : 32'h0000_0000)) else $error("x select");
	y_select_a: assert property (o_y_switch_select ==
		(o_current_drive_pulse ? 16'h0001 << yi : 16'h0000)) else $error("y select");
	y_onehot_a: assert property ($onehot0(o_y_switch_select)) else $error("y hot");
	x_onehot_a: assert property ($onehot0(o_x_switch_select)) else $error("x hot");
	row_side_a: assert property (ra || rb |-> rb == $past(i_rom_addr_lower[7]))
		else $error("row side");
	row_excl_a: assert property (!(ra && rb)) else $error("both rows");
	strobe_rows_a: assert property (ra || rb |-> o_local_strobe) else $error("strobe");
	double_rail_a: assert property (ra || rb |=>
		o_data_reg_set_line == ~o_data_reg_clear_line) else $error("double rail");
endmodule
bind mrsd_top mrsd_top_chk u_chk (.*);

// [mrsd_proc_model.sv]
`timescale 1ns/1ps
module mrsd_proc_model (
	input wire logic i_clk,
	output logic [7:0] o_up,
	output logic [7:0] o_lo,
	output logic o_drive,
	output logic o_strobe
);
	initial begin
		o_up = 8'h00;
		o_lo = 8'h00;
		o_drive = 1'b0;
		o_strobe = 1'b0;
	end
	task automatic access(input logic [7:0] u, input logic [7:0] l);
		@(posedge i_clk) #1;
		o_up = u;
		o_lo = l;
		o_drive = 1'b1;
		@(posedge i_clk) #1;
		o_strobe = 1'b1;
		repeat (3) @(posedge i_clk);
		#1 o_strobe = 1'b0;
		o_drive = 1'b0;
		repeat (2) @(posedge i_clk);
		#1 o_up = ~u;
		o_lo = ~l;
	endtask
endmodule

// [microcode_rom_select_decode_tb_top.sv]
`timescale 1ns/1ps
module microcode_rom_select_decode_tb_top;
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [7:0] i_rom_addr_upper, i_rom_addr_lower, u, l;
	logic i_proc_drive_timing, i_proc_strobe_timing;
	logic [15:0] i_row_a_sense, i_row_b_sense, o_data_reg_set_line, o_data_reg_clear_line, s;
	logic [31:0] o_x_switch_select;
	logic [15:0] o_y_switch_select;
	logic o_current_drive_pulse, o_local_strobe, o_row_a_amp_clock, o_row_b_amp_clock;
	logic o_board1_row_a_strobe_en, o_board1_row_b_strobe_en;
	logic o_board2_row_a_strobe_en, o_board2_row_b_strobe_en;
	wire [3:0] en_1k;
	wire [1:0] clk_1k;
	wire [15:0] set_1k;
	wire [15:0] clr_1k;
	int n_fail = 0;
	int n_tests = 0;
	always #50 i_core_clk = ~i_core_clk;
	mrsd_top #(.ROM_WORDS(2048)) u_dut (.*);
	mrsd_top #(.ROM_WORDS(1024)) u_dut_1k (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_rom_addr_upper(i_rom_addr_upper), .i_rom_addr_lower(i_rom_addr_lower),
		.i_proc_drive_timing(i_proc_drive_timing), .i_proc_strobe_timing(i_proc_strobe_timing),
		.i_row_a_sense(i_row_a_sense), .i_row_b_sense(i_row_b_sense),
		.o_x_switch_select(), .o_y_switch_select(), .o_current_drive_pulse(), .o_local_strobe(),
		.o_board1_row_a_strobe_en(en_1k[0]), .o_board1_row_b_strobe_en(en_1k[1]),
		.o_board2_row_a_strobe_en(en_1k[2]), .o_board2_row_b_strobe_en(en_1k[3]),
		.o_row_a_amp_clock(clk_1k[1]), .o_row_b_amp_clock(clk_1k[0]),
		.o_data_reg_set_line(set_1k), .o_data_reg_clear_line(clr_1k));
	mrsd_proc_model u_proc (.i_clk(i_core_clk), .o_up(i_rom_addr_upper),
		.o_lo(i_rom_addr_lower), .o_drive(i_proc_drive_timing), .o_strobe(i_proc_strobe_timing));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		i_row_a_sense = 16'h0000;
		i_row_b_sense = 16'h0000;
		void'($urandom(40989));
		repeat (20) @(posedge i_core_clk);
		#1 i_resetn = 1'b1;
		repeat (3) @(posedge i_core_clk);
		#1;
		for (int i = 0; i < 32; i++) begin
			u = $urandom;
			l = $urandom;
			i_row_a_sense = $urandom;
			i_row_b_sense = $urandom;
			fork
				u_proc.access(u, l);
				begin
					repeat (4) @(posedge i_core_clk);
					#2;
					check(o_x_switch_select, 32'h0000_0001 << {u[6], l[0], l[1], l[2], l[3]});
					check(o_y_switch_select, 32'h0000_0001 << {u[7], l[4], l[5], l[6]});
					check({o_board2_row_b_strobe_en, o_board2_row_a_strobe_en, o_board1_row_b_strobe_en,
						o_board1_row_a_strobe_en}, u[4] ? 0 : 32'h0000_0001 << {u[5], l[7]});
					check({o_row_a_amp_clock, o_row_b_amp_clock}, u[4] ? 0 : {~l[7], l[7]});
					s = l[7] ? i_row_b_sense : i_row_a_sense;
					check({o_data_reg_set_line, o_data_reg_clear_line}, u[4] ? 0 : {s, ~s});
					check(en_1k, 32'h0000_0001 << l[7]);
					check(clk_1k, {~l[7], l[7]});
					check({set_1k, clr_1k}, {s, ~s});
				end
			join
		end
		tally_and_finish();
	end
endmodule
